/* inc/uart_cfg.svh */
`ifndef UART_CFG_SVH
`define UART_CFG_SVH
// register byte offsets
`define OFS_BAUD 12'h000
`define OFS_MODE 12'h004
`define OFS_ERR 12'h008
`define OFS_RBUF 12'h00c
`define OFS_TSR 12'h010
// serial mode register fields
`define BIT_POWER 7
`define BIT_TXEN 6
`define BIT_RXEN 5
`define PAR_HI 4
`define PAR_LO 3
`define BIT_LEN8 2
// divider register fields
`define SEL_HI 7
`define SEL_LO 6
`define DIV_HI 4
// error status fields
`define ERR_PAR 2
`define ERR_FRM 1
`define ERR_OVR 0
// reset values
`define BAUD_RST 8'h08
`define MODE_RST 8'h04
// smallest legal division value
`define K_MIN 5'h08
`endif

/* inc/uart_pkg.sv */
package uart_pkg;
   // receive sequencer states
   typedef enum logic [2:0] {
      RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP
   } rx_state_t;
   // parity modes of the mode register
   typedef enum logic [1:0] {
      PAR_NONE = 2'h0, PAR_ZERO = 2'h1, PAR_ODD = 2'h2, PAR_EVEN = 2'h3
   } par_mode_t;
   // whole block state
   typedef struct packed {
      logic [7:0] bdc;
      logic [7:0] mode;
      logic [2:0] err;
      logic [7:0] rbuf;
      logic rfull;
      logic [7:0] tdata;
      logic tload;
      logic [31:0] prdata;
      logic slverr;
      logic tmr_d;
      logic [4:0] presc;
      logic btick;
      logic sync1;
      logic sync2;
      logic sync3;
      logic pin;
      logic smp;
      logic filt;
      logic filt_d;
      rx_state_t rxst;
      logic [4:0] rxcnt;
      logic rxhalf;
      logic [2:0] bitn;
      logic [7:0] shreg;
      logic pbit;
      logic rxint;
      logic [4:0] txcnt;
      logic txhalf;
      logic txtick;
   } state_t;
endpackage

/* verilog/uart_rx_error_and_baud_gen.sv */
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/10ps
`include "uart_cfg.svh"

module uart_rx_error_and_baud_gen (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // serial line and timer source
   input wire logic serial_input_pin,
   input wire logic eight_bit_timer_output,
   // to the rest of the unit
   output logic unit_power_on,
   output logic transmit_enable_bit,
   output logic receive_enable_bit,
   output logic base_clock_tick,
   output logic tx_bit_tick,
   output logic tx_load,
   output logic [7:0] tx_data,
   output logic receive_complete_interrupt
);
   import uart_pkg::*;

   // ***************************************
   // helpers
   // ***************************************

   // out-of-range division values run as the smallest legal one
   function automatic logic [4:0] eff_k(input logic [4:0] v);
      eff_k = (v < `K_MIN) ? `K_MIN : v;
   endfunction

   function automatic logic mapped(input logic [11:0] a);
      mapped = (a == `OFS_BAUD) || (a == `OFS_MODE) || (a == `OFS_ERR) ||
               (a == `OFS_RBUF) || (a == `OFS_TSR);
   endfunction

   state_t r;
   state_t n;

   logic wr;
   logic rd;
   logic pwr;
   logic rxon;
   logic txon;
   logic tick;
   logic fall;
   logic samp;
   logic stop_evt;
   logic rd_buf;
   logic ovr;
   logic perr;
   logic [4:0] km1;
   logic [2:0] last_bit;
   par_mode_t pmode;

   // ***************************************
   // next-state logic
   // ***************************************

   // whole block in one process
   always_comb begin
      n = r;
      n.rxint = 1'b0;
      n.tload = 1'b0;
      n.txtick = 1'b0;
      wr = psel && penable && pwrite;
      rd = psel && penable && !pwrite;
      rd_buf = rd && (paddr == `OFS_RBUF);
      pwr = r.mode[`BIT_POWER];
      rxon = pwr && r.mode[`BIT_RXEN];
      txon = pwr && r.mode[`BIT_TXEN];
      pmode = par_mode_t'(r.mode[`PAR_HI:`PAR_LO]);
      km1 = eff_k(r.bdc[`DIV_HI:0]) - 5'h01;
      last_bit = r.mode[`BIT_LEN8] ? 3'h7 : 3'h6;
      tick = 1'b0;
      samp = 1'b0;
      stop_evt = 1'b0;
      ovr = 1'b0;
      perr = 1'b0;

      // read data is latched in the setup phase
      if (psel && !penable) begin
         n.slverr = !mapped(paddr);
         unique case (paddr)
            `OFS_BAUD: n.prdata = {24'h000000, r.bdc};
            `OFS_MODE: n.prdata = {24'h000000, r.mode};
            `OFS_ERR: n.prdata = {29'h00000000, r.err};
            `OFS_RBUF: n.prdata = {24'h000000, r.rbuf};
            `OFS_TSR: n.prdata = {24'h000000, r.tdata};
            default: n.prdata = 32'h00000000;
         endcase
      end

      // register writes
      if (wr) begin
         unique case (paddr)
            `OFS_BAUD: n.bdc = pwdata[7:0];
            `OFS_MODE: n.mode = pwdata[7:0];
            `OFS_TSR: begin
               n.tdata = pwdata[7:0];
               n.tload = txon;
            end
            default: n.bdc = r.bdc;
         endcase
      end

      // read side effects, placed before the sets so a set wins
      if (rd && (paddr == `OFS_ERR)) begin
         n.err = 3'h0;
      end
      if (rd_buf) begin
         n.rfull = 1'b0;
      end

      // prescaler runs only while powered
      n.tmr_d = eight_bit_timer_output;
      n.presc = pwr ? r.presc + 5'h01 : 5'h00;
      unique case (r.bdc[`SEL_HI:`SEL_LO])
         2'h0: tick = eight_bit_timer_output && !r.tmr_d;
         2'h1: tick = r.presc[0];
         2'h2: tick = &r.presc[2:0];
         2'h3: tick = &r.presc;
      endcase
      n.btick = pwr && tick;

      // line synchroniser; a level counts once stages two and three agree
      n.sync1 = serial_input_pin;
      n.sync2 = r.sync1;
      n.sync3 = r.sync2;
      if (r.sync2 == r.sync3) begin
         n.pin = r.sync3;
      end

      // match detector: two agreeing base-clock samples, two clocks late
      if (r.btick) begin
         n.smp = r.pin;
         if (r.pin == r.smp) begin
            n.filt = r.pin;
         end
      end
      n.filt_d = r.filt;
      fall = r.filt_d && !r.filt;

      // receive counter: k base ticks per half bit
      if (rxon && (r.rxst != RX_IDLE) && r.btick) begin
         if (r.rxcnt == km1) begin
            n.rxcnt = 5'h00;
            n.rxhalf = !r.rxhalf;
            samp = (r.rxst == RX_START) || r.rxhalf;
         end else begin
            n.rxcnt = r.rxcnt + 5'h01;
         end
      end

      // receive sequencer
      if (!rxon) begin
         n.rxst = RX_IDLE;
         n.rxcnt = 5'h00;
         n.rxhalf = 1'b0;
      end else begin
         unique case (r.rxst)
            RX_IDLE: begin
               if (fall) begin
                  n.rxst = RX_START;
                  n.rxcnt = 5'h00;
                  n.rxhalf = 1'b0;
               end
            end
            RX_START: begin
               if (samp) begin
                  n.rxhalf = 1'b0;
                  if (!r.filt) begin
                     n.rxst = RX_DATA;
                     n.bitn = 3'h0;
                     n.shreg = 8'h00;
                  end else begin
                     n.rxst = RX_IDLE;
                     n.rxcnt = 5'h00;
                  end
               end
            end
            RX_DATA: begin
               if (samp) begin
                  n.shreg[r.bitn] = r.filt;
                  n.bitn = r.bitn + 3'h1;
                  if (r.bitn == last_bit) begin
                     n.rxst = (pmode == PAR_NONE) ? RX_STOP : RX_PAR;
                  end
               end
            end
            RX_PAR: begin
               if (samp) begin
                  n.pbit = r.filt;
                  n.rxst = RX_STOP;
               end
            end
            RX_STOP: begin
               if (samp) begin
                  stop_evt = 1'b1;
               end
            end
            default: n.rxst = RX_IDLE;
         endcase
      end

      // end of frame: flags, interrupt and buffer in one cycle
      if (stop_evt) begin
         n.rxst = RX_IDLE;
         n.rxcnt = 5'h00;
         n.rxhalf = 1'b0;
         n.rxint = 1'b1;
         unique case (pmode)
            PAR_ODD: perr = !(^{r.shreg, r.pbit});
            PAR_EVEN: perr = ^{r.shreg, r.pbit};
            default: perr = 1'b0;
         endcase
         if (perr) begin
            n.err[`ERR_PAR] = 1'b1;
         end
         if (!r.filt) begin
            n.err[`ERR_FRM] = 1'b1;
         end
         // a read of the buffer in this same cycle frees it
         ovr = r.rfull && !rd_buf;
         if (ovr) begin
            n.err[`ERR_OVR] = 1'b1;
         end else begin
            n.rbuf = r.shreg;
            n.rfull = 1'b1;
         end
      end

      // transmit counter; the shift stage uses the bit tick
      if (!txon || n.tload) begin
         n.txcnt = 5'h00;
         n.txhalf = 1'b0;
      end else if (r.btick) begin
         if (r.txcnt == km1) begin
            n.txcnt = 5'h00;
            n.txhalf = !r.txhalf;
            n.txtick = r.txhalf;
         end else begin
            n.txcnt = r.txcnt + 5'h01;
         end
      end
   end

   // ***************************************
   // state register
   // ***************************************

   // idle line levels so no false start after reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
         r.bdc <= `BAUD_RST;
         r.mode <= `MODE_RST;
         r.rxst <= RX_IDLE;
         r.sync1 <= 1'b1;
         r.sync2 <= 1'b1;
         r.sync3 <= 1'b1;
         r.pin <= 1'b1;
         r.smp <= 1'b1;
         r.filt <= 1'b1;
         r.filt_d <= 1'b1;
      end else begin
         r <= n;
      end
   end

   // ***************************************
   // outputs
   // ***************************************

   // zero wait states; read data was set up a cycle early
   assign pready = 1'b1;
   assign pslverr = r.slverr;
   assign prdata = r.prdata;
   assign unit_power_on = r.mode[`BIT_POWER];
   assign transmit_enable_bit = r.mode[`BIT_TXEN];
   assign receive_enable_bit = r.mode[`BIT_RXEN];
   assign base_clock_tick = r.btick;
   assign tx_bit_tick = r.txtick;
   assign tx_load = r.tload;
   assign tx_data = r.tdata;
   assign receive_complete_interrupt = r.rxint;

   // ***************************************
   // assertions
   // ***************************************

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence err_read_s;
      psel && penable && !pwrite && (paddr == `OFS_ERR) && !stop_evt;
   endsequence

   a_int_on_error: assert property (
      (r.err & ~$past(r.err)) != 3'h0 |-> r.rxint)
      else $error("error flag set without interrupt");

   a_err_read_clear: assert property (
      err_read_s |=> r.err == 3'h0)
      else $error("status read did not clear flags");

   a_framing_flag: assert property (
      stop_evt && !r.filt |=> r.err[`ERR_FRM] && r.rxint)
      else $error("low stop bit not flagged");

   a_overrun_flag: assert property (
      stop_evt && r.rfull && !rd_buf |=> r.err[`ERR_OVR])
      else $error("overrun not flagged");

   a_filter_agree: assert property (
      r.filt != $past(r.filt) |-> $past(r.btick) && ($past(r.pin) == $past(r.smp)))
      else $error("filter changed without agreeing samples");

   a_base_gated: assert property (
      !r.mode[`BIT_POWER] |=> !r.btick)
      else $error("base clock ran while unpowered");

   a_tx_held: assert property (
      !(r.mode[`BIT_POWER] && r.mode[`BIT_TXEN]) |=> r.txcnt == 5'h00)
      else $error("transmit counter not held");

   a_tx_load_clr: assert property (
      r.tload |-> r.txcnt == 5'h00 ##1 r.txcnt <= 5'h01)
      else $error("transmit counter not cleared on load");

   a_rx_held: assert property (
      !rxon |=> r.rxst == RX_IDLE && r.rxcnt == 5'h00)
      else $error("receive counter not held");

   a_rx_halt: assert property (
      r.rxst == RX_IDLE && !fall |=> r.rxcnt == 5'h00 && r.rxst == RX_IDLE)
      else $error("receive counter ran between frames");

   a_overrun_keep: assert property (
      stop_evt && ovr |=> r.rbuf == $past(r.rbuf) && r.rfull)
      else $error("overrun overwrote buffer");

   a_start_reject: assert property (
      r.rxst == RX_START && samp && r.filt |=> r.rxst == RX_IDLE)
      else $error("high line accepted as start");

endmodule

/* bench/remote_node.sv */
`timescale 1ns/10ps
// ***********************************
// far serial node, transmit side only
// ***********************************
module remote_node (
   // clock of the bench
   input wire logic pclk,
   // serial line, idle high
   output logic line
);
   // pclk cycles in one bit, fixed at 32; the bench keeps this default
   int bt = 32;
   initial line = 1'b1;
   // one bit held for a whole bit time
   task automatic bitout(input logic b);
      @(posedge pclk);
      line <= b;
      repeat (bt - 1) @(posedge pclk);
   endtask
   // start, lsb first data, optional parity, one stop, idle gap
   task automatic send(input logic [7:0] d, input int nb, par, input logic pb, stp);
      int i;
      bitout(1'b0);
      for (i = 0; i < nb; i++) bitout(d[i]);
      if (par != 0) bitout(pb);
      bitout(stp);
      bitout(1'b1);
   endtask
   // low pulse of w pclk cycles, far shorter than a bit
   task automatic glitch(input int w);
      @(posedge pclk);
      line <= 1'b0;
      repeat (w) @(posedge pclk);
      line <= 1'b1;
   endtask
endmodule

/* bench/uart_rx_error_and_baud_gen_tb.sv */
`timescale 1ns/10ps
`include "uart_cfg.svh"
module uart_rx_error_and_baud_gen_tb;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, tmr = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rv;
   logic pready, pslverr, se, rxd, pwr, txe, rxe, btk, ttk, tld, irq;
   logic [7:0] txd;
   int fails = 0, total_checks = 0, nld = 0, i, n;
   // ***********************************
   // clock, timer source, design, far node
   // ***********************************
   always #12.5 pclk = ~pclk;
   // timer rises every second pclk, same rate as the /2 source
   always @(posedge pclk) tmr <= ~tmr;
   always @(posedge pclk) if (tld === 1'b1) nld++;
   remote_node rn (.pclk(pclk), .line(rxd));
   uart_rx_error_and_baud_gen uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .serial_input_pin(rxd),
      .eight_bit_timer_output(tmr), .unit_power_on(pwr), .transmit_enable_bit(txe),
      .receive_enable_bit(rxe), .base_clock_tick(btk), .tx_bit_tick(ttk),
      .tx_load(tld), .tx_data(txd), .receive_complete_interrupt(irq));
   // ***********************************
   // shared tasks
   // ***********************************
   task final_report;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task bail;
      fails++;
      final_report;
   endtask
   task chk(input string nm, input logic [31:0] g, e);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   // apb transfer; waits on pready, bounded
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      for (k = 0; k < 50; k++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (k == 50) bail;
      rv = prdata;
      se = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task wait_irq;
      int k;
      for (k = 0; k < 2000; k++) begin
         @(posedge pclk);
         if (irq === 1'b1) return;
      end
      bail;
   endtask
   // cycles until the next transmit bit tick
   task tick(output int c);
      c = 0;
      do begin
         @(posedge pclk);
         c++;
      end while (ttk !== 1'b1 && c < 3000);
      if (c >= 3000) bail;
   endtask
   // counts pulses of a base tick (sel 0) or bit tick (sel 1)
   task pulses(input int sel, cyc, output int c);
      c = 0;
      repeat (cyc) begin
         @(posedge pclk);
         if ((sel == 0 ? btk : ttk) === 1'b1) c++;
      end
   endtask
   task per(input logic [7:0] bd, input int e);
      apb(1, `OFS_BAUD, {24'h0, bd});
      // first interval may be cut short by the divider change
      tick(n);
      tick(n);
      tick(n);
      chk("period", n, e);
   endtask
   // one frame, then error status and optionally the buffer
   task rx(input logic [7:0] d, input int nb, par, input logic pb, stp,
      input logic [2:0] e, input logic rd, input logic [7:0] b);
      fork
         rn.send(d, nb, par, pb, stp);
         wait_irq;
      join
      apb(0, `OFS_ERR, 0);
      chk("err", rv, {29'h0, e});
      if (rd) begin
         apb(0, `OFS_RBUF, 0);
         chk("rbuf", rv, {24'h0, b});
      end
   endtask
   task quiet(input int cyc);
      int c;
      c = 0;
      repeat (cyc) begin
         @(posedge pclk);
         if (irq === 1'b1) c++;
      end
      chk("irq count", c, 0);
   endtask
   // ***********************************
   // main sequence
   // ***********************************
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1;
      apb(0, `OFS_BAUD, 0);
      chk("baud", rv, 32'h08);
      apb(0, `OFS_MODE, 0);
      chk("mode", rv, 32'h04);
      apb(0, 12'h0f0, 0);
      chk("slverr", se, 1);
      pulses(0, 100, n);
      chk("gated base", n, 0);
      apb(1, `OFS_MODE, 32'h84);
      pulses(0, 100, n);
      chk("base ticks", n, 50);
      pulses(1, 200, n);
      chk("tx stopped", n, 0);
      apb(1, `OFS_MODE, 32'hc4);
      // the write lands at the access edge; look one edge later
      @(posedge pclk);
      chk("enables", {pwr, txe, rxe}, 3'b110);
      // every source select, k at both ends and below range
      per(8'h08, 32);
      per(8'h48, 32);
      per(8'h88, 128);
      per(8'hc8, 512);
      per(8'h5f, 124);
      per(8'h45, 32);
      nld = 0;
      apb(1, `OFS_TSR, 32'ha5);
      repeat (3) @(posedge pclk);
      chk("tx load", nld, 1);
      chk("tx data", txd, 8'ha5);
      apb(1, `OFS_BAUD, 32'h48);
      apb(1, `OFS_MODE, 32'he4);
      rx(8'h55, 8, 0, 0, 1, 3'b000, 1, 8'h55);
      apb(1, `OFS_MODE, 32'he0);
      rx(8'h36, 7, 0, 0, 1, 3'b000, 1, 8'h36);
      apb(1, `OFS_MODE, 32'he4);
      rx(8'ha3, 8, 0, 0, 0, 3'b010, 1, 8'ha3);
      apb(0, `OFS_ERR, 0);
      chk("err cleared", rv, 0);
      rx(8'h11, 8, 0, 0, 1, 3'b000, 0, 8'h00);
      rx(8'h22, 8, 0, 0, 1, 3'b001, 1, 8'h11);
      // parity modes: even, odd, zero
      apb(1, `OFS_MODE, 32'hfc);
      rx(8'h01, 8, 1, 0, 1, 3'b100, 1, 8'h01);
      rx(8'h01, 8, 1, 1, 1, 3'b000, 1, 8'h01);
      apb(1, `OFS_MODE, 32'hf4);
      rx(8'h01, 8, 1, 0, 1, 3'b000, 1, 8'h01);
      rx(8'h01, 8, 1, 1, 1, 3'b100, 1, 8'h01);
      apb(1, `OFS_MODE, 32'hec);
      rx(8'h01, 8, 1, 1, 1, 3'b000, 1, 8'h01);
      // receiver off: a whole frame passes unseen
      apb(1, `OFS_MODE, 32'hc4);
      fork
         rn.send(8'h0f, 8, 0, 0, 1);
         quiet(500);
      join
      apb(1, `OFS_MODE, 32'he4);
      rn.glitch(1);
      quiet(500);
      // long enough to start a frame, gone again at the start sample
      rn.glitch(6);
      quiet(500);
      final_report;
   end
endmodule
